//--- rtl/external_bus_interface.sv
// What this block does
// (R1) mode pins pick single, expanded, boot, reserved
// (R2) boot mode needs flash protect held high
// (R3) drive address bits 12..30, never bit 31
// (R4) one chip select per external channel
// (R5) byte strobes mark valid write lanes
// (R6) read samples 16 bits, passes valid lanes
// (R7) read strobe asserted during external reads
// (R8) low wait input stretches the access
// (R9) external master requests bus by pulling low
// (R10) low hold request forces hold, bus idle
// (R11) hold grant asserted once in hold
// (R12) float bus in hold, drop grant, resume
module external_bus_interface
    import ext_bus_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // mode straps and flash protect
    input wire logic [1:0] modePins,
    input wire logic flashProtectIn,
    output logic [1:0] opMode,
    output logic modeFault,
    // internal request side
    input wire logic reqValid,
    input wire bus_req_t req,
    output logic reqDone,
    output logic [15:0] rdData,
    // external bus pins
    output bus_pins_t pins,
    output logic pinsOe,
    output logic [15:0] dataOut,
    output logic dataOe,
    input wire logic [15:0] dataIn,
    input wire logic waitN,
    input wire logic busHoldRequestN,
    output logic busHoldGrant
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCESS = 2'b01,
        ST_HOLD = 2'b10
    } state_t;

    // three-stage synchronisers for pin inputs; change counts when stages 2 and 3 agree
    logic [SYNC_STAGES-1:0] waitSync_reg, holdSync_reg;
    logic waitLow_reg, holdReq_reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            waitSync_reg <= 3'b111;
            holdSync_reg <= 3'b111;
            waitLow_reg <= 1'b0;
            holdReq_reg <= 1'b0;
        end else begin
            waitSync_reg <= {waitSync_reg[1:0], waitN};
            holdSync_reg <= {holdSync_reg[1:0], busHoldRequestN};
            if (waitSync_reg[1] == waitSync_reg[2]) waitLow_reg <= ~waitSync_reg[2];
            if (holdSync_reg[1] == holdSync_reg[2]) holdReq_reg <= ~holdSync_reg[2]; // see (R9)
        end
    end

    // mode capture: straps sampled each reset cycle, frozen after release
    logic [1:0] opMode_reg;
    logic modeFault_reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            opMode_reg <= modePins; // see (R1)
        end
    end
    wire bootNoProtect = (opMode_reg == MODE_BOOT) && !flashProtectIn; // see (R2)
    wire reservedMode = (opMode_reg == MODE_RESERVED);
    always_ff @(posedge ref_clk) begin
        if (rst) modeFault_reg <= 1'b0;
        else modeFault_reg <= reservedMode || bootNoProtect; // see (R1) (R2)
    end
    assign opMode = opMode_reg;
    assign modeFault = modeFault_reg;

    // bus usable only in expanded or boot mode
    wire extEnabled = (opMode_reg == MODE_EXPANDED) || (opMode_reg == MODE_BOOT);

    state_t state_reg, state_next;
    bus_req_t cur_reg;
    bus_pins_t pins_reg, pins_next;
    logic pinsOe_reg, dataOe_reg, grant_reg, done_reg;
    logic [15:0] dataOut_reg, rdData_reg, rdData_next;

    // sampled read data keeps only the valid lanes
    wire [15:0] laneMask = {{8{cur_reg.lanes[0]}}, {8{cur_reg.lanes[1]}}};
    assign rdData_next = dataIn & laneMask; // see (R6)

    // next state
    wire startAccess = reqValid && extEnabled && !reservedMode;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (holdReq_reg) state_next = ST_HOLD; // see (R10)
                else if (startAccess) state_next = ST_ACCESS;
            end
            ST_ACCESS: begin
                if (!waitLow_reg) state_next = holdReq_reg ? ST_HOLD : ST_IDLE; // see (R8)
            end
            ST_HOLD: begin
                if (!holdReq_reg) state_next = ST_IDLE; // see (R12)
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // pin values for the cycle being entered
    wire [1:0] chanSel = cur_reg.addr[CHAN_BIT] ? 2'b10 : 2'b01;
    always_comb begin
        pins_next = '0;
        if (state_next == ST_ACCESS) begin
            pins_next.addr = (state_reg == ST_IDLE) ? req.addr[ADDR_MSB:ADDR_LSB] // see (R3)
                                                     : cur_reg.addr[ADDR_MSB:ADDR_LSB];
            pins_next.chipSel = (state_reg == ST_IDLE) ? (req.addr[CHAN_BIT] ? 2'b10 : 2'b01)
                                                        : chanSel; // see (R4)
            if (state_reg == ST_IDLE) begin
                pins_next.readStrobe = !req.write; // see (R7)
                pins_next.upperStrobe = req.write && req.lanes[1]; // see (R5)
                pins_next.lowerStrobe = req.write && req.lanes[0]; // see (R5)
            end else begin
                pins_next.readStrobe = !cur_reg.write;
                pins_next.upperStrobe = cur_reg.write && cur_reg.lanes[1];
                pins_next.lowerStrobe = cur_reg.write && cur_reg.lanes[0];
            end
        end
    end

    // state, request latch, pins and grant
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cur_reg <= '0;
            pins_reg <= '0;
            pinsOe_reg <= 1'b0;
            dataOe_reg <= 1'b0;
            dataOut_reg <= 16'h0000;
            grant_reg <= 1'b0;
            done_reg <= 1'b0;
            rdData_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            pins_reg <= pins_next;
            if (state_reg == ST_IDLE && state_next == ST_ACCESS) begin
                cur_reg <= req;
                dataOut_reg <= req.wdata;
            end
            // bus floats in hold and outside expanded/boot
            pinsOe_reg <= extEnabled && (state_next != ST_HOLD); // see (R12)
            dataOe_reg <= (state_next == ST_ACCESS) &&
                          ((state_reg == ST_IDLE) ? req.write : cur_reg.write); // see (R12)
            grant_reg <= (state_next == ST_HOLD); // see (R11)
            done_reg <= (state_reg == ST_ACCESS) && !waitLow_reg;
            if (state_reg == ST_ACCESS && !waitLow_reg && !cur_reg.write) rdData_reg <= rdData_next;
        end
    end

    assign pins = pins_reg;
    assign pinsOe = pinsOe_reg;
    assign dataOut = dataOut_reg;
    assign dataOe = dataOe_reg;
    assign busHoldGrant = grant_reg;
    assign reqDone = done_reg;
    assign rdData = rdData_reg;

    // checks
    a_grant_floats: assert property (@(posedge ref_clk) disable iff (rst)
        busHoldGrant |-> !pinsOe && !dataOe) else $error("bus driven during hold"); // see (R12)
    a_hold_entry: assert property (@(posedge ref_clk) disable iff (rst)
        (holdReq_reg && state_reg == ST_IDLE) |=> busHoldGrant) else $error("hold not granted"); // see (R10)
    a_grant_drop: assert property (@(posedge ref_clk) disable iff (rst)
        (busHoldGrant && !holdReq_reg) |=> !busHoldGrant) else $error("grant not released"); // see (R11)
    a_wait_stretch: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == ST_ACCESS && waitLow_reg) |=> state_reg == ST_ACCESS) else $error("wait ignored"); // see (R8)
    a_read_strobe: assert property (@(posedge ref_clk) disable iff (rst)
        pins.readStrobe |-> !dataOe && !pins.upperStrobe && !pins.lowerStrobe)
        else $error("read strobe with write"); // see (R7)
    a_one_select: assert property (@(posedge ref_clk) disable iff (rst)
        pins.chipSel != 2'b11) else $error("both selects active"); // see (R4)
    a_strobe_access: assert property (@(posedge ref_clk) disable iff (rst)
        (pins.upperStrobe || pins.lowerStrobe) |-> dataOe && pins.chipSel != 2'b00)
        else $error("strobe outside write"); // see (R5)
    a_mode_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (opMode == MODE_SINGLE) |-> !pinsOe) else $error("bus driven in single-chip"); // see (R1)

    // completion is a single-cycle pulse
    a_done_pulse: assert property (@(posedge ref_clk) disable iff (rst) // see (R8)
        reqDone |=> !reqDone)
        else $error("done held too long");

    // grant only while the state machine holds
    a_grant_state: assert property (@(posedge ref_clk) disable iff (rst) // see (R11)
        busHoldGrant |-> state_reg == ST_HOLD)
        else $error("grant outside hold");

    // no select or read strobe while the bus is handed over
    a_hold_quiet: assert property (@(posedge ref_clk) disable iff (rst) // see (R10)
        (state_reg == ST_HOLD) |-> pins.chipSel == 2'b00 && !pins.readStrobe)
        else $error("bus used during hold");

    // lanes outside the access come back as zero
    a_read_lanes: assert property (@(posedge ref_clk) disable iff (rst) // see (R6)
        (reqDone && !cur_reg.write) |-> (rdData & ~laneMask) == 16'h0000)
        else $error("invalid lane passed");

    // single-chip and reserved modes never start an access
    a_mode_refuse: assert property (@(posedge ref_clk) disable iff (rst) // see (R1)
        (state_reg == ST_IDLE && !extEnabled) |=> state_reg != ST_ACCESS)
        else $error("access in refused mode");

    // boot mode without flash protect raises the fault flag
    a_boot_fault: assert property (@(posedge ref_clk) disable iff (rst) // see (R2)
        (opMode == MODE_BOOT && !flashProtectIn) |=> modeFault)
        else $error("boot fault missed");

    // data lines only driven with the address pins
    a_data_drive: assert property (@(posedge ref_clk) disable iff (rst) // see (R12)
        dataOe |-> pinsOe)
        else $error("data driven alone");
endmodule // external_bus_interface

//--- inc/ext_bus_pkg.sv
package ext_bus_pkg;
    // operating mode as selected by the two mode pins
    typedef enum logic [1:0] {
        MODE_SINGLE   = 2'b00,
        MODE_EXPANDED = 2'b01,
        MODE_BOOT     = 2'b10,
        MODE_RESERVED = 2'b11
    } op_mode_t;

    // pin geometry
    localparam int ADDR_LSB = 12;
    localparam int ADDR_MSB = 30;
    localparam int ADDR_PINS = ADDR_MSB - ADDR_LSB + 1;
    localparam int DATA_W = 16;
    // address bit that picks the chip-select channel (2 KB per channel)
    localparam int CHAN_BIT = 11;
    // reset values
    localparam logic [1:0] MODE_RESET = 2'b00;
    localparam int SYNC_STAGES = 3;

    // internal access request
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [1:0] lanes;   // [1] upper lane D0-D7, [0] lower lane D8-D15
        logic [15:0] wdata;
    } bus_req_t;

    // external pin group
    typedef struct packed {
        logic [ADDR_PINS-1:0] addr;
        logic [1:0] chipSel;
        logic readStrobe;
        logic upperStrobe;
        logic lowerStrobe;
    } bus_pins_t;
endpackage

//--- testbench/ext_bus_model.sv
// external memory with one word per chip-select channel
module ext_bus_model
    import ext_bus_pkg::*;
(
    // bus pins from the device
    input wire logic ref_clk,
    input wire bus_pins_t pins,
    input wire logic pinsOe,
    input wire logic [15:0] dataOut,
    input wire logic dataOe,
    // stall command and answers
    input wire logic stall,
    output logic [15:0] dataIn,
    output logic waitN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [2] = '{16'h0000, 16'h0000};
    logic [15:0] lastOut = 16'h0000;
    wire chan = pins.chipSel[1];
    wire rdNow = pinsOe && pins.readStrobe;
    // wait line and read data, released bus shows inverted last value
    assign waitN = !stall;
    assign dataIn = rdNow ? mem[chan] : ~lastOut;
    // lane stores, upper lane is low byte
    always @(posedge ref_clk) begin
        if (rdNow) lastOut <= mem[chan];
        if (pinsOe && dataOe && pins.upperStrobe) mem[chan][7:0] <= dataOut[7:0];
        if (pinsOe && dataOe && pins.lowerStrobe) mem[chan][15:8] <= dataOut[15:8];
    end
endmodule // ext_bus_model

//--- testbench/external_bus_interface_test.sv
module external_bus_interface_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ext_bus_pkg::*;
    logic ref_clk = 0, rst = 1, flashProtectIn = 0, reqValid = 0, stall = 0, busHoldRequestN = 1;
    logic [1:0] modePins = 2'b00, opMode;
    logic modeFault, reqDone, pinsOe, dataOe, busHoldGrant, waitN;
    bus_req_t req = '0;
    bus_pins_t pins;
    logic [15:0] rdData, dataOut, dataIn;
    logic [15:0] shadow [2] = '{16'h0000, 16'h0000};
    logic [16:0] expQ [$];
    logic [16:0] e;
    logic [31:0] seed = 32'h0000_88D1, r;
    logic [1:0] md;
    int errors = 0, checksDone = 0, n;
    always #25 ref_clk = ~ref_clk;
    external_bus_interface DUT (.ref_clk, .rst, .modePins, .flashProtectIn, .opMode, .modeFault, .reqValid,
        .req, .reqDone, .rdData, .pins, .pinsOe, .dataOut, .dataOe, .dataIn, .waitN, .busHoldRequestN, .busHoldGrant);
    ext_bus_model peer (.ref_clk, .pins, .pinsOe, .dataOut, .dataOe, .stall, .dataIn, .waitN);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic ok, input string m);
        checksDone++;
        if (!ok) begin
            errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", errors, checksDone);
        if (errors == 0 && checksDone > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one request pulse, note expectation, bounded wait for completion
    task automatic access(input logic wr, input logic [1:0] ln, input logic ch, input logic ok);
        logic [31:0] a;
        logic [15:0] m;
        a = rnd();
        m = {{8{ln[0]}}, {8{ln[1]}}};
        if (ok) expQ.push_back({!wr, shadow[ch] & m});
        if (ok && wr) shadow[ch] = (shadow[ch] & ~m) | (a[15:0] & m);
        @(posedge ref_clk);
        req <= '{addr: {a[31:12], ch, a[10:0]}, write: wr, lanes: ln, wdata: a[15:0]};
        reqValid <= 1'b1;
        @(posedge ref_clk);
        reqValid <= 1'b0;
        for (n = 0; n < 40 && reqDone !== 1'b1; n++) @(posedge ref_clk);
        chk(ok ? n < 40 : n == 40, "completion");
    endtask
    // result and pin watcher
    always @(posedge ref_clk) begin
        if (reqDone === 1'b1) begin
            if (expQ.size() == 0) chk(0, "spurious done");
            else begin
                e = expQ.pop_front();
                if (e[16]) chk(rdData === e[15:0], "read data");
            end
        end
        if (pinsOe === 1'b1 && (pins.readStrobe | pins.upperStrobe | pins.lowerStrobe))
            chk(pins.addr === req.addr[30:12] && pins.chipSel === {req.addr[11], !req.addr[11]}
                && pins.readStrobe === !req.write
                && (!req.write || {pins.upperStrobe, pins.lowerStrobe} === req.lanes), "pins");
        if (dataOe === 1'b1) chk(dataOut === req.wdata, "write data");
        if (busHoldGrant === 1'b1) chk(pinsOe === 1'b0 && dataOe === 1'b0, "hold float");
    end
    // modes, accesses, stall and hold
    initial begin
        for (int m = 0; m < 8; m++) begin
            md = m[1:0] ^ 2'b10;
            modePins <= md;
            flashProtectIn <= m[2];
            rst <= 1'b1;
            repeat (2) @(posedge ref_clk);
            rst <= 1'b0;
            repeat (2) @(posedge ref_clk);
            chk(opMode === md && modeFault === (md == 3 || (md == 2 && !m[2])), "mode");
            for (int k = 0; k < 3; k++) begin
                r = rnd();
                access(1'b1, r[1:0] == 0 ? 2'b11 : r[1:0], r[2], md == 1 || md == 2);
                access(1'b0, r[4:3], r[2], md == 1 || md == 2);
            end
        end
        stall <= 1'b1;
        repeat (5) @(posedge ref_clk);
        fork
            access(1'b0, 2'b11, 1'b0, 1'b1);
            begin
                repeat (8) @(posedge ref_clk);
                stall <= 1'b0;
            end
        join
        chk(n > 6 && n < 40, "wait stretch");
        busHoldRequestN <= 1'b0;
        for (n = 0; n < 10 && busHoldGrant !== 1'b1; n++) @(posedge ref_clk);
        chk(busHoldGrant === 1'b1 && pinsOe === 1'b0, "hold grant");
        access(1'b1, 2'b11, 1'b1, 1'b0);
        busHoldRequestN <= 1'b1;
        for (n = 0; n < 10 && busHoldGrant !== 1'b0; n++) @(posedge ref_clk);
        chk(busHoldGrant === 1'b0, "hold release");
        access(1'b0, 2'b11, 1'b1, 1'b1);
        test_done();
    end
endmodule // external_bus_interface_test
